/* File: cdch_assertions.sv */
// cdch_assertions: port-level checks of the done/chain handshake.
// assumes binding to cdch_top; everything checked lives on clk.
`default_nettype none

module cdch_assertions (
    // ****
    // watched ports
    // ****
    input wire logic clk,
    input wire logic rst,
    input wire logic config_request_n,
    input wire logic config_done_line_in,
    input wire logic config_done_line_out,
    input wire logic config_done_line_oe_n,
    input wire logic config_status_line_n_out,
    input wire logic config_status_line_n_oe_n,
    input wire logic chain_enable_in_n,
    input wire logic chain_out_option,
    input wire logic chain_enable_out_n,
    input wire logic config_clock_oe_n,
    input wire logic serial_cmd_out,
    input wire logic serial_memory_select_n,
    input wire logic user_mode,
    input wire logic config_error
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    chk_od_never_high: assert property (!config_done_line_out
        && !config_status_line_n_out) else $error("open drain high");
    chk_done_load_low: assert property (!config_clock_oe_n
        |-> !config_done_line_oe_n) else $error("done released in load");
    chk_user_released: assert property (user_mode
        |-> config_done_line_oe_n) else $error("done pulled in user");
    chk_init_done_seen: assert property ($rose(user_mode)
        |-> $past(config_done_line_in, 3)) else $error("init without done");
    chk_chain_blocks: assert property (chain_enable_in_n [*4]
        |=> !$rose(config_done_line_oe_n)) else $error("load w/o enable");
    chk_chain_handoff: assert property ($stable(chain_out_option)
        && chain_out_option |-> chain_enable_out_n == !user_mode)
        else $error("chain output wrong");
    chk_status_error: assert property (config_error
        == !config_status_line_n_oe_n) else $error("status vs error");
    chk_request_reset: assert property (!config_request_n [*5]
        |-> !user_mode && !config_error) else $error("request low kept");
    chk_user_holds: assert property (user_mode && config_request_n
        |=> user_mode) else $error("user mode lost");
    chk_cmd_idle_high: assert property (serial_memory_select_n
        |-> serial_cmd_out) else $error("command out of frame");
    chk_select_clock: assert property ($fell(serial_memory_select_n)
        |-> !config_clock_oe_n) else $error("select without clock");
endmodule

bind cdch_top cdch_assertions cdch_assertions_i (
    .clk(clk), .rst(rst), .config_request_n(config_request_n),
    .config_done_line_in(config_done_line_in),
    .config_done_line_out(config_done_line_out),
    .config_done_line_oe_n(config_done_line_oe_n),
    .config_status_line_n_out(config_status_line_n_out),
    .config_status_line_n_oe_n(config_status_line_n_oe_n),
    .chain_enable_in_n(chain_enable_in_n),
    .chain_out_option(chain_out_option),
    .chain_enable_out_n(chain_enable_out_n),
    .config_clock_oe_n(config_clock_oe_n),
    .serial_cmd_out(serial_cmd_out),
    .serial_memory_select_n(serial_memory_select_n),
    .user_mode(user_mode), .config_error(config_error)
);

`default_nettype wire

/* File: cdch_fifo.sv */
// cdch_fifo: single-clock byte buffer with valid/ready on both sides.
// assumes DEPTH is a power of two; clear drops all stored words.
`default_nettype none

module cdch_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clear,
    // fill side
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    // drain side
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic      [WIDTH-1:0] rd_data
);

    // ****************************************************************
    // storage and pointers
    // ****************************************************************
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic [AW:0]      count;
    wire              push = wr_valid & wr_ready;
    wire              pop  = rd_valid & rd_ready;

    assign wr_ready = (count != FULL);
    assign rd_valid = (count != '0);
    assign rd_data  = mem[rp];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp] <= wr_data;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wp    <= '0;
            rp    <= '0;
            count <= '0;
        end
        else if (clear)
        begin
            wp    <= '0;
            rp    <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wp <= wp + 1'b1;
            if (pop)
                rp <= rp + 1'b1;
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

endmodule

`default_nettype wire

/* File: cdch_partner.sv */
// cdch_partner: serial memory (active) and bit source (passive).
// assumes the bench calls send() only while the device loads.
`default_nettype none

module cdch_partner (
    // from the device
    input wire logic         config_clock_out,
    input wire logic         serial_memory_select_n,
    input wire logic         serial_cmd_out,
    // toward the device
    output logic             config_clock_in,
    output logic             serial_config_data_in,
    output logic      [31:0] cmd_seen
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // memory and source
    // ****
    localparam logic [7:0] AS_PAT = 8'hA5;
    logic        ps_bit = 1'b1;
    logic        as_bit = 1'b1;
    logic [15:0] cnt = 16'h0;
    initial {config_clock_in, cmd_seen} = 33'h0;
    assign serial_config_data_in = serial_memory_select_n ? ps_bit : as_bit;
    // command shifted in on rise while selected
    always @(posedge config_clock_out or posedge serial_memory_select_n)
        if (serial_memory_select_n)
            cnt <= 16'h0;
        else
        begin
            if (cnt < 16'h20)
                cmd_seen <= {cmd_seen[30:0], serial_cmd_out};
            cnt <= cnt + 16'h1;
        end
    // data after the 32 command bits, changed on fall; pull-up before
    always @(negedge config_clock_out)
        if (cnt >= 16'h20)
            as_bit <= AS_PAT[3'h7 - cnt[2:0]];
    // clock only within a frame; line inverted after, no stale bit
    task automatic send(input logic [7:0] b, input int n = 8);
        for (int i = n - 1; i >= 0; i--)
        begin
            ps_bit = b[i];
            #3 config_clock_in = 1'b1;
            #3 config_clock_in = 1'b0;
        end
        ps_bit = ~ps_bit;
        #60;
    endtask
endmodule

`default_nettype wire

/* File: cdch_pkg.sv */
// cdch_pkg: constants, states and carriers of the done/chain handshake.
// assumes a 50 MHz system clock and one configuration byte stream.
`default_nettype none

package cdch_pkg;

    // ****************************************************************
    // clocking and counts
    // ****************************************************************
    localparam int          CLK_HZ        = 50_000_000;
    // config_clock half period in system clocks (active serial)
    localparam logic [2:0]  AS_HALF_LAST  = 3'h3;
    // cycles spent in initialization once the done line reads high
    localparam logic [4:0]  INIT_LAST     = 5'h0F;
    // command plus address length on the serial command output
    localparam logic [4:0]  CMD_LAST      = 5'h1F;
    localparam logic [2:0]  BIT_LAST      = 3'h7;

    // ****************************************************************
    // serial memory readout
    // ****************************************************************
    localparam logic [7:0]  AS_READ_CMD   = 8'h03;
    localparam logic [23:0] AS_START_ADDR = 24'h000000;

    // ****************************************************************
    // buffer shape and reset values
    // ****************************************************************
    localparam int          FIFO_WIDTH    = 8;
    localparam int          FIFO_DEPTH    = 8;
    // sync order: data, mode, status, done, chain enable, request
    localparam logic [5:0]  SYNC_RESET    = 6'h2E;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_LOAD    = 6'h02,
        ST_RELEASE = 6'h04,
        ST_INIT    = 6'h08,
        ST_USER    = 6'h10,
        ST_ERROR   = 6'h20
    } cdch_state_e;

    typedef enum logic [2:0] {
        AS_OFF  = 3'h1,
        AS_CMD  = 3'h2,
        AS_DATA = 3'h4
    } cdch_as_e;

    // open-drain drive: oe_n low pulls the pin to the out level
    typedef struct packed {
        logic out;
        logic oe_n;
    } cdch_od_s;

endpackage

`default_nettype wire

/* File: cdch_top.sv */
// cdch_top: configuration done line, status line, chain enable pair and
// serial bit capture (passive on config_clock, active from a memory).
// assumes open-drain pins are resolved outside; bytes leave on cfg_*.
// Operation
// - hold done line low until data complete
// - release done line before initialization begins
// - ignore external done low in user mode
// - finish initialization only after done reads high
// - accept configuration only with chain enable low
// - drive chain output low when configured
// - option off makes chain pin user io
// - active serial drives command out to memory
// - active serial drives memory select low
// - error pulls status low; external low errors in load, release and init
// - request low resets, rising edge restarts
// - passive serial captures bit on clock rise
// - active serial generates config_clock itself
`default_nettype none

module cdch_top (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // configuration request and mode strap
    input  wire logic       config_request_n,
    input  wire logic       active_serial_mode,
    // done line, open drain
    input  wire logic       config_done_line_in,
    output logic            config_done_line_out,
    output logic            config_done_line_oe_n,
    // status line, open drain
    input  wire logic       config_status_line_n_in,
    output logic            config_status_line_n_out,
    output logic            config_status_line_n_oe_n,
    // chain enable pair
    input  wire logic       chain_enable_in_n,
    input  wire logic       chain_out_option,
    input  wire logic       user_chain_pin_out,
    input  wire logic       user_chain_pin_oe_n,
    output logic            chain_enable_out_n,
    output logic            chain_enable_out_oe_n,
    // configuration clock and serial data
    input  wire logic       config_clock_in,
    output logic            config_clock_out,
    output logic            config_clock_oe_n,
    input  wire logic       serial_config_data_in,
    output logic            serial_cmd_out,
    output logic            serial_memory_select_n,
    // byte stream to the configuration engine
    output logic      [7:0] cfg_data,
    output logic            cfg_valid,
    input  wire logic       cfg_ready,
    input  wire logic       load_done,
    input  wire logic       load_error,
    // status toward user logic
    output logic            user_mode,
    output logic            config_error
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic       req_prev;
    wire  [5:0] pins_raw = {serial_config_data_in, active_serial_mode,
                            config_status_line_n_in, config_done_line_in,
                            chain_enable_in_n, config_request_n};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1    <= cdch_pkg::SYNC_RESET;
            sync2    <= cdch_pkg::SYNC_RESET;
            req_prev <= 1'b0;
        end
        else
        begin
            sync1    <= pins_raw;
            sync2    <= sync1;
            req_prev <= sync2[0];
        end
    end

    wire req_n_s  = sync2[0];
    wire ce_n_s   = sync2[1];
    wire done_s   = sync2[2];
    wire status_s = sync2[3];
    wire mode_s   = sync2[4];
    wire data_s   = sync2[5];
    // a rising edge seen after reset starts the first load
    wire req_rise = req_n_s & ~req_prev;

    // ****************************************************************
    // main sequence
    // ****************************************************************
    cdch_pkg::cdch_state_e state;
    cdch_pkg::cdch_state_e next_state;
    logic                  mode_as;
    logic [4:0]            init_cnt;
    logic                  overrun;
    cdch_pkg::cdch_od_s    done_drv;
    cdch_pkg::cdch_od_s    status_drv;

    // status is released outside ST_ERROR, so a low here is external
    wire ext_status_low = ~status_s;
    wire in_load        = (state == cdch_pkg::ST_LOAD);
    wire load_fault     = load_error | overrun | ext_status_low;
    wire init_end       = (init_cnt == cdch_pkg::INIT_LAST);

    always_comb
    begin
        next_state = state;
        unique case (state)
            cdch_pkg::ST_IDLE:
                if (req_rise)
                    next_state = cdch_pkg::ST_LOAD;
            cdch_pkg::ST_LOAD:
                if (load_fault)
                    next_state = cdch_pkg::ST_ERROR;
                else if (load_done & ~ce_n_s)
                    next_state = cdch_pkg::ST_RELEASE;
            cdch_pkg::ST_RELEASE:
                if (ext_status_low)
                    next_state = cdch_pkg::ST_ERROR;
                else if (done_s)
                    next_state = cdch_pkg::ST_INIT;
            cdch_pkg::ST_INIT:
                if (ext_status_low)
                    next_state = cdch_pkg::ST_ERROR;
                else if (init_end)
                    next_state = cdch_pkg::ST_USER;
            cdch_pkg::ST_USER:
                next_state = cdch_pkg::ST_USER;
            cdch_pkg::ST_ERROR:
                next_state = cdch_pkg::ST_ERROR;
        endcase
        if (~req_n_s)
            next_state = cdch_pkg::ST_IDLE;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state    <= cdch_pkg::ST_IDLE;
            mode_as  <= 1'b0;
            init_cnt <= '0;
        end
        else
        begin
            state    <= next_state;
            if (state == cdch_pkg::ST_IDLE)
                mode_as <= mode_s;
            if (state == cdch_pkg::ST_INIT)
                init_cnt <= init_cnt + 1'b1;
            else
                init_cnt <= '0;
        end
    end

    // ****************************************************************
    // open-drain drives and status outputs
    // ****************************************************************
    // done stays low through idle, load and error; never driven high
    wire done_hold = (next_state == cdch_pkg::ST_IDLE) |
                     (next_state == cdch_pkg::ST_LOAD) |
                     (next_state == cdch_pkg::ST_ERROR);
    wire fin       = (next_state == cdch_pkg::ST_USER);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            done_drv     <= '{out: 1'b0, oe_n: 1'b0};
            status_drv   <= '{out: 1'b0, oe_n: 1'b1};
            user_mode    <= 1'b0;
            config_error <= 1'b0;
        end
        else
        begin
            done_drv.oe_n   <= ~done_hold;
            status_drv.oe_n <= (next_state != cdch_pkg::ST_ERROR);
            user_mode       <= fin;
            config_error    <= (next_state == cdch_pkg::ST_ERROR);
        end
    end

    assign config_done_line_out      = done_drv.out;
    assign config_done_line_oe_n     = done_drv.oe_n;
    assign config_status_line_n_out  = status_drv.out;
    assign config_status_line_n_oe_n = status_drv.oe_n;

    // ****************************************************************
    // chain enable output
    // ****************************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            chain_enable_out_n    <= 1'b1;
            chain_enable_out_oe_n <= 1'b1;
        end
        else if (chain_out_option)
        begin
            chain_enable_out_n    <= ~fin;
            chain_enable_out_oe_n <= 1'b0;
        end
        else
        begin
            // pin idles with its pull-up until user logic takes it
            chain_enable_out_n    <= fin & user_chain_pin_out;
            chain_enable_out_oe_n <= ~fin | user_chain_pin_oe_n;
        end
    end

    // ****************************************************************
    // active serial readout
    // ****************************************************************
    cdch_pkg::cdch_as_e as_phase;
    logic [2:0]         div_cnt;
    logic [4:0]         as_bits;
    logic [31:0]        cmd_shift;
    logic [7:0]         as_byte;
    logic               as_pending;
    logic               sck;
    logic               fifo_wr_ready;

    wire as_go   = in_load & mode_as & ~ce_n_s;
    // holding the clock while a byte waits stalls the memory, not data
    wire as_tick = as_go & ~as_pending & (as_phase != cdch_pkg::AS_OFF) &
                   (div_cnt == cdch_pkg::AS_HALF_LAST);
    wire rise    = as_tick & ~sck;
    wire fall    = as_tick & sck;
    wire as_push = as_pending & fifo_wr_ready;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            as_phase   <= cdch_pkg::AS_OFF;
            div_cnt    <= '0;
            as_bits    <= '0;
            cmd_shift  <= '0;
            as_byte    <= '0;
            as_pending <= 1'b0;
            sck        <= 1'b0;
        end
        else if (~(in_load & mode_as))
        begin
            as_phase   <= cdch_pkg::AS_OFF;
            div_cnt    <= '0;
            as_pending <= 1'b0;
            sck        <= 1'b0;
        end
        else
        begin
            if (as_go & ~as_pending)
                div_cnt <= as_tick ? 3'h0 : div_cnt + 1'b1;
            if (as_go & (as_phase == cdch_pkg::AS_OFF))
            begin
                as_phase  <= cdch_pkg::AS_CMD;
                as_bits   <= '0;
                cmd_shift <= {cdch_pkg::AS_READ_CMD,
                              cdch_pkg::AS_START_ADDR};
            end
            if (as_tick)
                sck <= ~sck;
            if (fall & (as_phase == cdch_pkg::AS_CMD))
            begin
                cmd_shift <= {cmd_shift[30:0], 1'b0};
                as_bits   <= as_bits + 1'b1;
                if (as_bits == cdch_pkg::CMD_LAST)
                    as_phase <= cdch_pkg::AS_DATA;
            end
            if (rise & (as_phase == cdch_pkg::AS_DATA))
            begin
                as_byte <= {as_byte[6:0], data_s};
                as_bits <= {2'b00, as_bits[2:0] + 3'h1};
                if (as_bits[2:0] == cdch_pkg::BIT_LAST)
                    as_pending <= 1'b1;
            end
            if (as_push)
                as_pending <= 1'b0;
        end
    end

    assign config_clock_out       = sck;
    assign config_clock_oe_n      = ~(in_load & mode_as);
    assign serial_cmd_out         = cmd_shift[31] |
                                    (as_phase != cdch_pkg::AS_CMD);
    assign serial_memory_select_n = (as_phase == cdch_pkg::AS_OFF);

    // ****************************************************************
    // passive serial capture on config_clock
    // ****************************************************************
    logic       run_l1;
    logic       run_l2;
    logic [2:0] ps_cnt;
    logic [6:0] ps_shift;
    logic [7:0] ps_hold [2];
    logic       ps_tog;

    wire ps_run = in_load & ~mode_as & ~ce_n_s;
    logic ps_run_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ps_run_q <= 1'b0;
        else
            ps_run_q <= ps_run;
    end

    always_ff @(posedge config_clock_in or posedge rst)
    begin
        if (rst)
        begin
            run_l1     <= 1'b0;
            run_l2     <= 1'b0;
            ps_cnt     <= '0;
            ps_shift   <= '0;
            ps_hold[0] <= '0;
            ps_hold[1] <= '0;
            ps_tog     <= 1'b0;
        end
        else
        begin
            run_l1 <= ps_run_q;
            run_l2 <= run_l1;
            if (~run_l2)
                ps_cnt <= '0;
            else
            begin
                ps_shift <= {ps_shift[5:0], serial_config_data_in};
                ps_cnt   <= ps_cnt + 1'b1;
                if (ps_cnt == cdch_pkg::BIT_LAST)
                begin
                    // alternate buffers so a byte stays put while crossing
                    ps_hold[~ps_tog] <= {ps_shift, serial_config_data_in};
                    ps_tog           <= ~ps_tog;
                end
            end
        end
    end

    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    wire  ps_push_req = (tog_s2 ^ tog_s3) & in_load & ~mode_as;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tog_s1  <= 1'b0;
            tog_s2  <= 1'b0;
            tog_s3  <= 1'b0;
            overrun <= 1'b0;
        end
        else
        begin
            tog_s1  <= ps_tog;
            tog_s2  <= tog_s1;
            tog_s3  <= tog_s2;
            // passive source cannot be stalled: a full buffer is an error
            overrun <= ps_push_req & ~fifo_wr_ready & in_load;
        end
    end

    wire [7:0] ps_byte     = ps_hold[tog_s2];

    // ****************************************************************
    // byte buffer toward the configuration engine
    // ****************************************************************
    wire       fifo_wr_valid = mode_as ? as_push : ps_push_req;
    wire [7:0] fifo_wr_data  = mode_as ? as_byte : ps_byte;
    wire       fifo_clear    = (state == cdch_pkg::ST_IDLE);

    cdch_fifo #(
        .WIDTH (cdch_pkg::FIFO_WIDTH),
        .DEPTH (cdch_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .clear    (fifo_clear),
        .wr_valid (fifo_wr_valid),
        .wr_ready (fifo_wr_ready),
        .wr_data  (fifo_wr_data),
        .rd_valid (cfg_valid),
        .rd_ready (cfg_ready),
        .rd_data  (cfg_data)
    );

endmodule

`default_nettype wire

/* File: tb_top.sv */
// tb_top: drives cdch_top through passive, error and active loads.
// assumes cdch_partner answers the serial side; pins resolved here.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst, config_request_n, active_serial_mode;
    logic        ext_done_low, ext_status_low, chain_enable_in_n;
    logic        chain_out_option, user_chain_pin_out, user_chain_pin_oe_n;
    logic        cfg_ready, load_done, load_error;
    wire logic   config_done_line_in, config_status_line_n_in;
    logic        config_done_line_out, config_done_line_oe_n;
    logic        config_status_line_n_out, config_status_line_n_oe_n;
    logic        chain_enable_out_n, chain_enable_out_oe_n;
    logic        config_clock_in, config_clock_out, config_clock_oe_n;
    logic        serial_config_data_in, serial_cmd_out;
    logic        serial_memory_select_n, cfg_valid, user_mode, config_error;
    logic [7:0]  cfg_data, got[$];
    logic [31:0] cmd_seen;
    int          num_errors = 0, check_count = 0;

    // open drain with pull-ups: low if anyone pulls
    assign config_done_line_in = config_done_line_oe_n && !ext_done_low;
    assign config_status_line_n_in =
        config_status_line_n_oe_n && !ext_status_low;
    cdch_top cdch_top_i (.*);
    cdch_partner cdch_partner_i (.*);
    always @(posedge clk)
        if (cfg_valid && cfg_ready)
            got.push_back(cfg_data);

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ****
    // helpers
    // ****
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_user;
        int i;
        for (i = 0; i < 100 && user_mode !== 1'b1; i++)
            tick(1);
        if (i == 100)
        begin
            num_errors++;
            $display("[FAIL] user_mode wait ran out");
            close_out;
        end
    endtask
    task automatic restart(input logic as_mode);
        {config_request_n, load_error} = 2'h0;
        active_serial_mode = as_mode;
        tick(8);
        chk("error cleared", config_error, 1'b0);
        chk("user cleared", user_mode, 1'b0);
        config_request_n = 1'b1;
        tick(6);
    endtask
    task automatic pulse_done;
        load_done = 1'b1;
        tick(1);
        load_done = 1'b0;
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset;
        chk("done pulled", config_done_line_oe_n, 1'b0);
        chk("status free", config_status_line_n_oe_n, 1'b1);
        chk("chain out", chain_enable_out_n, 1'b1);
        chk("select", serial_memory_select_n, 1'b1);
        chk("cfg_valid", cfg_valid, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_passive;
        restart(1'b0);
        pulse_done;
        tick(4);
        chk("done held", config_done_line_oe_n, 1'b0);
        chain_enable_in_n = 1'b0;
        tick(4);
        got.delete();
        cdch_partner_i.send(8'h00, 2);
        cdch_partner_i.send(8'h5A);
        cdch_partner_i.send(8'hC3);
        cdch_partner_i.send(8'h01);
        tick(8);
        chk("bytes", got.size(), 3);
        chk("byte0", got[0], 8'h5A);
        chk("byte2", got[2], 8'h01);
        ext_done_low = 1'b1;
        pulse_done;
        tick(1);
        chk("done free", config_done_line_oe_n, 1'b1);
        tick(40);
        chk("init waits", user_mode, 1'b0);
        ext_done_low = 1'b0;
        tick(14);
        chk("init length", user_mode, 1'b0);
        wait_user;
        chk("chain out low", chain_enable_out_n, 1'b0);
        {ext_done_low, ext_status_low} = 2'h3;
        tick(10);
        chk("user kept", user_mode, 1'b1);
        chk("no error", config_error, 1'b0);
        {ext_done_low, ext_status_low} = 2'h0;
        $display("test passive done");
    endtask
    task automatic t_error;
        restart(1'b0);
        ext_status_low = 1'b1;
        tick(5);
        ext_status_low = 1'b0;
        chk("ext error", config_error, 1'b1);
        pulse_done;
        tick(3);
        chk("error holds done", config_done_line_oe_n, 1'b0);
        restart(1'b0);
        load_error = 1'b1;
        tick(3);
        chk("load error", config_error, 1'b1);
        restart(1'b0);
        cfg_ready = 1'b0;
        for (int i = 0; i < 12; i++)
            cdch_partner_i.send(8'(i));
        tick(5);
        chk("overrun", config_error, 1'b1);
        chk("status low", config_status_line_n_oe_n, 1'b0);
        cfg_ready = 1'b1;
        $display("test error done");
    endtask
    task automatic t_active;
        chain_out_option = 1'b0;
        restart(1'b1);
        got.delete();
        chk("select low", serial_memory_select_n, 1'b0);
        chk("clock driven", config_clock_oe_n, 1'b0);
        chk("chain tri", chain_enable_out_oe_n, 1'b1);
        tick(420);
        chk("command", cmd_seen,
            {cdch_pkg::AS_READ_CMD, cdch_pkg::AS_START_ADDR});
        chk("mem byte0", got[0], 8'hA5);
        chk("mem byte1", got[1], 8'hA5);
        pulse_done;
        wait_user;
        chk("user pin", chain_enable_out_oe_n, 1'b0);
        chk("user level", chain_enable_out_n, 1'b1);
        $display("test active done");
    endtask

    initial
    begin
        {rst, config_request_n, active_serial_mode} = 3'h0;
        #1 rst = 1'b1;
        {ext_done_low, ext_status_low, load_done, load_error} = 4'h0;
        {chain_enable_in_n, chain_out_option} = 2'h3;
        {user_chain_pin_out, user_chain_pin_oe_n} = 2'h2;
        cfg_ready = 1'b1;
        tick(5);
        t_reset;
        rst = 1'b0;
        tick(2);
        t_passive;
        t_error;
        t_active;
        close_out;
    end
endmodule

`default_nettype wire
